// [inc/cpulp_pkg.sv]
// shared constants and carrier types for the low-power state controller
package cpulp_pkg;

  // two flip-flops are the least that settles an asynchronous request
  localparam int unsigned SYNC_STAGES        = 2;
  // junction trip point in degrees Celsius (125)
  localparam logic [7:0]  TRIP_TEMP_C        = 8'h7D;
  // cycles spent saving core state before the management acknowledge
  localparam int unsigned SMM_SAVE_CYCLES    = 4;
  // cycles within which bus outputs drop once bus reset is seen
  localparam int unsigned RESET_DRAIN_CYCLES = 2;

  typedef enum logic {
    CPULP_TXN_STOP_GRANT_ACK,
    CPULP_TXN_SMI_ACK
  } cpulp_txn_kind_t;

  typedef struct packed {
    logic            valid;
    cpulp_txn_kind_t kind;
  } cpulp_bus_txn_t;

  typedef struct packed {
    logic core;
    logic bus;
    logic local_interrupt_controller;
    logic pll;
  } cpulp_clk_en_t;

  typedef struct packed {
    cpulp_clk_en_t clk;
    logic          snoop;
    logic          intr;
    logic          exec;
  } cpulp_ctrl_t;

  localparam cpulp_bus_txn_t TXN_IDLE = '{valid: 1'h0, kind: CPULP_TXN_STOP_GRANT_ACK};
  localparam cpulp_ctrl_t CTRL_RESET = '{clk: '{core: 1'h1, bus: 1'h1, local_interrupt_controller: 1'h1, pll: 1'h1},
                                         snoop: 1'h1, intr: 1'h1, exec: 1'h1};

endpackage

// [src/cpulp_state_ctrl.sv]
// processor low-power and system-control state controller
`timescale 1ns/1ps
module cpulp_state_ctrl
  import cpulp_pkg::*;
#(
  parameter int unsigned SAVE_CYCLES = SMM_SAVE_CYCLES
) (
  input  wire logic       clock,
  input  wire logic       rstn,
  input  wire logic       bus_reset_n,
  input  wire logic       stop_clock_request_n,
  input  wire logic       sleep_request_n,
  input  wire logic       deep_sleep_request_n,
  input  wire logic       sys_mgmt_interrupt_n,
  input  wire logic       sys_mgmt_resume,
  input  wire logic [7:0] junction_temp_c,
  input  wire logic       bus_txn_taken,
  output cpulp_bus_txn_t  bus_txn,
  output cpulp_ctrl_t     ctrl,
  output logic            sys_mgmt_mode,
  output logic            overheat_trip_n,
  output logic            pin_out_en
);

  typedef enum logic [2:0] {
    ST_RUN,
    ST_STOP_ACK,
    ST_STOP_GRANT,
    ST_SLEEP,
    ST_DEEP_SLEEP,
    ST_SMM_SAVE,
    ST_SMM_ACK,
    ST_TRIP
  } cpulp_state_t;

  cpulp_state_t state;
  cpulp_state_t next_state;
  logic [1:0]   async_sync;
  logic         stop_act;
  logic         smi_act;
  logic         smi_act_q;
  logic         smi_edge;
  logic         smi_pending;
  logic         smi_accept;
  logic         bus_reset_act;
  logic         bus_reset_q;
  logic         reset_release;
  logic         trip;
  logic         trip_det;
  logic         txn_done;
  logic [7:0]   save_cnt;

  initial begin
    if (SAVE_CYCLES < 1 || SAVE_CYCLES > 255) begin
      $error("SAVE_CYCLES must lie in 1..255");
    end
  end

  function automatic cpulp_ctrl_t decode(input cpulp_state_t s);
    cpulp_ctrl_t c;
    c = CTRL_RESET;
    case (s)
      ST_RUN, ST_SMM_SAVE: begin
        c = CTRL_RESET;
      end
      ST_STOP_ACK, ST_SMM_ACK: begin
        c.exec = 1'h0;
      end
      ST_STOP_GRANT: begin
        c.exec     = 1'h0;
        c.clk.core = 1'h0;
      end
      ST_SLEEP, ST_DEEP_SLEEP: begin
        c = '{clk: '{core: 1'h0, bus: 1'h0, local_interrupt_controller: 1'h0, pll: 1'h1},
              snoop: 1'h0, intr: 1'h0, exec: 1'h0};
      end
      ST_TRIP: begin
        c = '{clk: '{core: 1'h0, bus: 1'h0, local_interrupt_controller: 1'h0, pll: 1'h1},
              snoop: 1'h0, intr: 1'h0, exec: 1'h0};
      end
      default: begin
        c = CTRL_RESET;
      end
    endcase
    return c;
  endfunction

  // stop-clock and management requests cross through two flops; sleep, deep-sleep and bus reset are used unsynchronised
  cpulp_sync #(
    .WIDTH  (2),
    .STAGES (SYNC_STAGES)
  ) u_sync (
    .clock       (clock),
    .rstn        (rstn),
    .async_in    ({sys_mgmt_interrupt_n, stop_clock_request_n}),
    .reset_level (2'h3),
    .sync_out    (async_sync)
  );

  assign stop_act      = !async_sync[0];
  assign smi_act       = !async_sync[1];
  assign smi_edge      = smi_act && !smi_act_q;
  assign bus_reset_act = !bus_reset_n;
  assign reset_release = bus_reset_n && !bus_reset_q;
  assign trip_det      = trip || (junction_temp_c > TRIP_TEMP_C);
  assign txn_done      = bus_txn.valid && bus_txn_taken;
  assign smi_accept    = (state == ST_RUN) && smi_pending && !sys_mgmt_mode && !trip_det && !bus_reset_act;

  always_comb begin
    next_state = state;
    if (trip_det) begin
      next_state = ST_TRIP;
    end else if (bus_reset_act) begin
      next_state = ST_RUN;
    end else begin
      case (state)
        ST_RUN: begin
          if (smi_accept) begin
            next_state = ST_SMM_SAVE;
          end else if (stop_act) begin
            next_state = ST_STOP_ACK;
          end
        end
        ST_STOP_ACK: begin
          if (txn_done) begin
            next_state = ST_STOP_GRANT;
          end
        end
        ST_STOP_GRANT: begin
          if (!stop_act) begin
            next_state = ST_RUN;
          end else if (!sleep_request_n) begin
            next_state = ST_SLEEP;
          end
        end
        ST_SLEEP: begin
          if (sleep_request_n) begin
            next_state = ST_STOP_GRANT;
          end else if (!deep_sleep_request_n) begin
            next_state = ST_DEEP_SLEEP;
          end
        end
        ST_DEEP_SLEEP: begin
          if (deep_sleep_request_n) begin
            next_state = ST_SLEEP;
          end
        end
        ST_SMM_SAVE: begin
          if (save_cnt == 8'(SAVE_CYCLES - 1)) begin
            next_state = ST_SMM_ACK;
          end
        end
        ST_SMM_ACK: begin
          if (txn_done) begin
            next_state = ST_RUN;
          end
        end
        ST_TRIP: begin
          next_state = ST_TRIP;
        end
        default: begin
          next_state = ST_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state <= ST_RUN;
      ctrl  <= CTRL_RESET;
    end else begin
      state <= next_state;
      ctrl  <= decode(next_state);
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      save_cnt <= 8'h00;
    end else if (state == ST_SMM_SAVE) begin
      save_cnt <= save_cnt + 8'h01;
    end else begin
      save_cnt <= 8'h00;
    end
  end

  // acknowledge is posted on entry and held until the bus takes it or a bus reset or trip drops it
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      bus_txn <= TXN_IDLE;
    end else if (bus_reset_act || trip_det) begin
      bus_txn <= TXN_IDLE;
    end else if (next_state == ST_STOP_ACK && state != ST_STOP_ACK) begin
      bus_txn <= '{valid: 1'h1, kind: CPULP_TXN_STOP_GRANT_ACK};
    end else if (next_state == ST_SMM_ACK && state != ST_SMM_ACK) begin
      bus_txn <= '{valid: 1'h1, kind: CPULP_TXN_SMI_ACK};
    end else if (txn_done) begin
      bus_txn <= TXN_IDLE;
    end
  end

  // edges arriving in Sleep are dropped; a new edge beats the accept clear
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      smi_act_q   <= 1'h0;
      smi_pending <= 1'h0;
    end else begin
      smi_act_q <= smi_act;
      if (bus_reset_act) begin
        smi_pending <= 1'h0;
      end else if (smi_edge && state != ST_SLEEP && state != ST_DEEP_SLEEP) begin
        smi_pending <= 1'h1;
      end else if (smi_accept) begin
        smi_pending <= 1'h0;
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sys_mgmt_mode <= 1'h0;
    end else if (bus_reset_act) begin
      sys_mgmt_mode <= 1'h0;
    end else if (state == ST_SMM_ACK && txn_done) begin
      sys_mgmt_mode <= 1'h1;
    end else if (sys_mgmt_resume) begin
      sys_mgmt_mode <= 1'h0;
    end
  end

  // the trip is sticky: only power-on reset clears it, the part is unsafe
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      trip            <= 1'h0;
      overheat_trip_n <= 1'h1;
    end else begin
      trip            <= trip_det;
      overheat_trip_n <= !trip_det;
    end
  end

  // level of the management request caught at the bus reset release edge
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      bus_reset_q <= 1'h1;
      pin_out_en  <= 1'h1;
    end else begin
      bus_reset_q <= bus_reset_n;
      if (reset_release) begin
        pin_out_en <= !smi_act;
      end
    end
  end

  AST_STOP_ACK_POSTED: assert property (@(posedge clock) disable iff (!rstn)
    state == ST_STOP_ACK |-> bus_txn.valid && bus_txn.kind == CPULP_TXN_STOP_GRANT_ACK)
    else $error("stop-grant acknowledge missing");

  AST_STOP_GRANT_GATING: assert property (@(posedge clock) disable iff (!rstn)
    state == ST_STOP_GRANT |-> !ctrl.clk.core && ctrl.clk.bus && ctrl.clk.local_interrupt_controller && ctrl.snoop && ctrl.intr)
    else $error("wrong clock gating in stop-grant");

  AST_STOP_EXIT: assert property (@(posedge clock) disable iff (!rstn)
    state == ST_STOP_GRANT && !stop_act && !trip_det |=> state == ST_RUN && ctrl.exec && ctrl.clk.core)
    else $error("stop-grant exit did not restart execution");

  AST_BUS_CLOCK_KEPT: assert property (@(posedge clock) disable iff (!rstn)
    $rose(stop_act) && state == ST_RUN |=> (ctrl.clk.bus || state == ST_TRIP) [*2])
    else $error("stop request touched bus clock");

  AST_SLEEP_ENTER: assert property (@(posedge clock) disable iff (!rstn)
    state == ST_STOP_GRANT && stop_act && !sleep_request_n && !trip_det && !bus_reset_act
    |=> state == ST_SLEEP && ctrl.clk == 4'h1)
    else $error("sleep entry or gating wrong");

  AST_SLEEP_DEAF: assert property (@(posedge clock) disable iff (!rstn)
    state == ST_SLEEP && !bus_reset_act |-> (!ctrl.snoop && !ctrl.intr) ##1 smi_pending == $past(smi_pending))
    else $error("sleep recognised a snoop or interrupt");

  AST_SLEEP_EXIT: assert property (@(posedge clock) disable iff (!rstn)
    state == ST_SLEEP && sleep_request_n && !trip_det && !bus_reset_act
    |=> state == ST_STOP_GRANT && ctrl.clk.bus)
    else $error("sleep release did not return to stop-grant");

  AST_DEEP_ENTER: assert property (@(posedge clock) disable iff (!rstn)
    state == ST_SLEEP && !sleep_request_n && !deep_sleep_request_n && !trip_det && !bus_reset_act
    |=> state == ST_DEEP_SLEEP)
    else $error("deep sleep not entered");

  AST_SMM_ENTER: assert property (@(posedge clock) disable iff (!rstn)
    smi_accept |=> state == ST_SMM_SAVE ##[1:255] bus_txn.valid && bus_txn.kind == CPULP_TXN_SMI_ACK)
    else $error("management acknowledge not issued");

  AST_SMM_MODE: assert property (@(posedge clock) disable iff (!rstn)
    state == ST_SMM_ACK && txn_done && !trip_det && !bus_reset_act |=> sys_mgmt_mode && ctrl.exec)
    else $error("management mode not entered after acknowledge");

  AST_TRISTATE: assert property (@(posedge clock) disable iff (!rstn)
    reset_release && smi_act |=> !pin_out_en)
    else $error("drivers left on with management request at release");

  AST_TRIP: assert property (@(posedge clock) disable iff (!rstn)
    junction_temp_c > TRIP_TEMP_C |=> !overheat_trip_n && !ctrl.exec && state == ST_TRIP)
    else $error("overheat did not halt");

  AST_RESET_DRAIN: assert property (@(posedge clock) disable iff (!rstn)
    bus_reset_act |-> ##[1:2] !bus_txn.valid)
    else $error("bus output held through reset");

  AST_SLEEP_IGNORED: assert property (@(posedge clock) disable iff (!rstn)
    state != ST_STOP_GRANT && state != ST_SLEEP && state != ST_DEEP_SLEEP |=> state != ST_SLEEP)
    else $error("sleep request acted outside stop-grant");

  COV_STOP_GRANT: cover property (@(posedge clock) disable iff (!rstn)
    state == ST_STOP_ACK ##1 state == ST_STOP_GRANT);
  COV_DEEP_SLEEP: cover property (@(posedge clock) disable iff (!rstn)
    state == ST_SLEEP ##1 state == ST_DEEP_SLEEP);
  COV_SMM: cover property (@(posedge clock) disable iff (!rstn)
    state == ST_SMM_ACK ##1 sys_mgmt_mode);
  COV_TRIP: cover property (@(posedge clock) disable iff (!rstn)
    $fell(overheat_trip_n));

endmodule // cpulp_state_ctrl

// [src/cpulp_sync.sv]
// multi-bit level synchroniser for asynchronous request pins
`timescale 1ns/1ps
module cpulp_sync
  import cpulp_pkg::*;
#(
  parameter int unsigned WIDTH  = 1,
  parameter int unsigned STAGES = SYNC_STAGES
) (
  input  wire logic             clock,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] async_in,
  input  wire logic [WIDTH-1:0] reset_level,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] chain [STAGES];

  initial begin
    if (STAGES < 2 || WIDTH < 1) begin
      $error("cpulp_sync needs at least two stages and one bit");
    end
  end

  // pins idle high (inactive), so reset loads all ones and no false request follows release

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < STAGES; i++) begin
        chain[i] <= '1;
      end
    end else begin
      chain[0] <= async_in;
      for (int i = 1; i < STAGES; i++) begin
        chain[i] <= chain[i-1];
      end
    end
  end

  assign sync_out = chain[STAGES-1];

  // reset_level kept for interface symmetry; must match idle level
  initial begin
    if (WIDTH > 64) begin
      $error("cpulp_sync width out of range");
    end
  end

endmodule // cpulp_sync

// [tb/cpulp_chipset_model.sv]
// chipset-side model: drives the request pins and accepts bus transactions
`timescale 1ns/1ps
module cpulp_chipset_model
  import cpulp_pkg::*;
(
  input  wire logic           clock,
  input  wire logic           rstn,
  input  wire logic [3:0]     want,
  input  wire logic [7:0]     taken_delay,
  input  wire cpulp_bus_txn_t bus_txn,
  output logic                stop_clock_request_n,
  output logic                sleep_request_n,
  output logic                deep_sleep_request_n,
  output logic                sys_mgmt_interrupt_n,
  output logic                bus_txn_taken
);
  logic [7:0] wait_cnt;

  // wants are active high; the pins are active-low levels
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      stop_clock_request_n <= 1'h1;
      sleep_request_n      <= 1'h1;
      deep_sleep_request_n <= 1'h1;
      sys_mgmt_interrupt_n <= 1'h1;
    end else begin
      stop_clock_request_n <= !want[0];
      sleep_request_n      <= !want[1];
      deep_sleep_request_n <= !want[2];
      sys_mgmt_interrupt_n <= !want[3];
    end
  end

  // taken_delay lets a scenario make the bus slow to accept
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wait_cnt      <= 8'h00;
      bus_txn_taken <= 1'h0;
    end else if (!bus_txn.valid || bus_txn_taken) begin
      wait_cnt      <= 8'h00;
      bus_txn_taken <= 1'h0;
    end else if (wait_cnt >= taken_delay) begin
      bus_txn_taken <= 1'h1;
    end else begin
      wait_cnt <= wait_cnt + 8'h01;
    end
  end
endmodule // cpulp_chipset_model

// [tb/cpulp_state_ctrl_bench.sv]
// self-checking bench for the low-power state controller
`timescale 1ns/1ps
`define CHECK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin err_count++; \
  $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); end end
module cpulp_state_ctrl_bench;
  import cpulp_pkg::*;
  logic           clock = 1'b0;
  logic           rstn = 1'b0;
  logic           bus_reset_n = 1'b1;
  logic [3:0]     want = 4'h0;
  logic [7:0]     taken_delay = 8'h00;
  logic           sys_mgmt_resume = 1'b0;
  logic [7:0]     junction_temp_c = 8'h19;
  logic           stop_n, sleep_n, deep_n, smi_n, taken;
  cpulp_bus_txn_t bus_txn;
  cpulp_ctrl_t    ctrl;
  logic           sys_mgmt_mode, overheat_trip_n, pin_out_en;
  int             err_count = 0;
  int             samples_checked = 0;
  int             cycles = 0;

  always #12.5 clock = !clock;

  cpulp_state_ctrl #(.SAVE_CYCLES(2)) DUT (
    .clock(clock), .rstn(rstn), .bus_reset_n(bus_reset_n), .stop_clock_request_n(stop_n),
    .sleep_request_n(sleep_n), .deep_sleep_request_n(deep_n), .sys_mgmt_interrupt_n(smi_n),
    .sys_mgmt_resume(sys_mgmt_resume), .junction_temp_c(junction_temp_c), .bus_txn_taken(taken),
    .bus_txn(bus_txn), .ctrl(ctrl), .sys_mgmt_mode(sys_mgmt_mode), .overheat_trip_n(overheat_trip_n),
    .pin_out_en(pin_out_en));

  cpulp_chipset_model chipset (
    .clock(clock), .rstn(rstn), .want(want), .taken_delay(taken_delay), .bus_txn(bus_txn),
    .stop_clock_request_n(stop_n), .sleep_request_n(sleep_n), .deep_sleep_request_n(deep_n),
    .sys_mgmt_interrupt_n(smi_n), .bus_txn_taken(taken));

  task automatic final_report();
    $display("checks %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // a hang ends the run through the same report
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      final_report();
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask

  task automatic set_want(input int idx, input logic val);
    @(posedge clock);
    want[idx] <= val;
  endtask

  // bounded wait; the caller compares the outcome
  task automatic wait_valid(input logic v);
    for (int i = 0; i < 40 && bus_txn.valid !== v; i++) begin
      @(negedge clock);
    end
  endtask

  task automatic test_stop_sleep_deep();
    set_want(0, 1'b1);
    wait_valid(1'b1);
    `CHECK(bus_txn, {1'b1, CPULP_TXN_STOP_GRANT_ACK})
    `CHECK(ctrl.exec, 1'b0)
    wait_valid(1'b0);
    cyc(2);
    `CHECK(ctrl, 7'h3E)
    set_want(1, 1'b1);
    cyc(3);
    `CHECK(ctrl, 7'h08)
    set_want(3, 1'b1);
    cyc(6);
    `CHECK(ctrl, 7'h08)
    set_want(2, 1'h1);
    cyc(3);
    `CHECK(ctrl, 7'h08)
    // deep sleep ignores a sleep release, so a steady ctrl shows it was entered
    set_want(1, 1'h0);
    cyc(3);
    `CHECK(ctrl, 7'h08)
    set_want(2, 1'h0);
    cyc(4);
    `CHECK(ctrl, 7'h3E)
    set_want(0, 1'b0);
    cyc(6);
    `CHECK(ctrl, 7'h7F)
    cyc(8);
    `CHECK(bus_txn.valid, 1'b0)
    `CHECK(sys_mgmt_mode, 1'b0)
    set_want(3, 1'b0);
    cyc(4);
  endtask

  // sleep and deep-sleep requests while running change nothing
  task automatic test_requests_in_run();
    set_want(1, 1'b1);
    set_want(2, 1'b1);
    cyc(6);
    `CHECK(ctrl, 7'h7F)
    `CHECK(bus_txn.valid, 1'b0)
    set_want(1, 1'b0);
    set_want(2, 1'b0);
    cyc(2);
  endtask

  task automatic test_mgmt_interrupt();
    taken_delay <= 8'h05;
    set_want(3, 1'b1);
    wait_valid(1'b1);
    `CHECK(bus_txn, {1'b1, CPULP_TXN_SMI_ACK})
    `CHECK(sys_mgmt_mode, 1'b0)
    wait_valid(1'b0);
    cyc(2);
    `CHECK(sys_mgmt_mode, 1'b1)
    `CHECK(ctrl.exec, 1'b1)
    set_want(3, 1'b0);
    @(posedge clock);
    sys_mgmt_resume <= 1'b1;
    @(posedge clock);
    sys_mgmt_resume <= 1'b0;
    cyc(2);
    `CHECK(sys_mgmt_mode, 1'b0)
    taken_delay <= 8'h00;
  endtask

  // slow bus leaves the ack posted while bus reset arrives
  task automatic test_bus_reset();
    taken_delay <= 8'h20;
    set_want(0, 1'b1);
    wait_valid(1'b1);
    set_want(3, 1'b1);
    cyc(3);
    @(posedge clock);
    bus_reset_n <= 1'b0;
    cyc(2);
    `CHECK(bus_txn.valid, 1'b0)
    set_want(0, 1'b0);
    @(posedge clock);
    bus_reset_n <= 1'b1;
    cyc(2);
    `CHECK(pin_out_en, 1'b0)
    set_want(3, 1'b0);
    cyc(3);
    @(posedge clock);
    bus_reset_n <= 1'b0;
    @(posedge clock);
    bus_reset_n <= 1'b1;
    cyc(2);
    `CHECK(pin_out_en, 1'b1)
    `CHECK(ctrl, 7'h7F)
    taken_delay <= 8'h00;
  endtask

  // exactly the trip point must not trip; one degree above must
  task automatic test_overheat();
    @(posedge clock);
    junction_temp_c <= TRIP_TEMP_C;
    cyc(3);
    `CHECK(overheat_trip_n, 1'b1)
    @(posedge clock);
    junction_temp_c <= TRIP_TEMP_C + 8'h01;
    cyc(2);
    `CHECK(overheat_trip_n, 1'b0)
    `CHECK(ctrl, 7'h08)
    @(posedge clock);
    junction_temp_c <= 8'h19;
    cyc(4);
    `CHECK(overheat_trip_n, 1'b0)
  endtask

  initial begin
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
    cyc(4);
    `CHECK(ctrl, 7'h7F)
    `CHECK(pin_out_en, 1'b1)
    test_stop_sleep_deep();
    test_requests_in_run();
    test_mgmt_interrupt();
    test_bus_reset();
    test_overheat();
    final_report();
  end
endmodule // cpulp_state_ctrl_bench
